// [hdl/ead_pkg.sv]
// Purpose: Shared constants for the external data space access unit
// Assumes: One 40 MHz clock; the core clock period is one or two of its cycles
// Notes:   Counts are in core clock periods unless named otherwise
package ead_pkg;
	// ------------------------------------------------------------------
	// Clock and bus cycle timing
	// ------------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ       = 40000000;
	localparam int unsigned OSC_PER_CPU_STD  = 2;      // Oscillator periods per core period, standard mode
	localparam int unsigned OSC_PER_CPU_X2   = 1;      // Oscillator periods per core period, double speed
	localparam int unsigned CYCLE_CPU        = 6;      // Core periods in one plain external access
	localparam logic [3:0]  ALE_TICKS        = 4'h1;   // Address latch phase
	localparam logic [3:0]  SETUP_TICKS      = 4'h1;   // Address held after latch strobe falls
	localparam logic [3:0]  STROBE_TICKS     = 4'h3;   // Read or write strobe width, plain
	localparam logic [3:0]  STROBE_LONG      = 4'hf;   // Read or write strobe width, stretched
	localparam logic [3:0]  HOLD_TICKS       = 4'h1;   // Data held after strobe rises
	// ------------------------------------------------------------------
	// Nonvolatile array geometry and map
	// ------------------------------------------------------------------
	localparam int unsigned NV_ADDR_W        = 11;     // 2 KB array
	localparam int unsigned NV_COL_W         = 7;      // Byte within page
	localparam int unsigned NV_ROW_W         = 4;      // Page row
	localparam int unsigned NV_PAGE_BYTES    = 128;
	localparam logic [15:0] NV_BASE          = 16'h0000;
	localparam logic [15:0] NV_LAST          = 16'h07ff;
	localparam logic [7:0]  NV_BLOCKED_DATA  = 8'hff;  // Answer to an array read while programming
	localparam int unsigned NV_PROG_CYCLES   = 4096;   // Programming time in sys_clk cycles
	// ------------------------------------------------------------------
	// Programming launch sequence
	// ------------------------------------------------------------------
	localparam logic [3:0]  LAUNCH_FIRST_HI  = 4'h5;   // Upper nibble of first write
	localparam logic [3:0]  LAUNCH_SECOND_HI = 4'ha;   // Upper nibble of second write
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	// ------------------------------------------------------------------
	// Bus sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ALE    = 3'b001,
		ST_SETUP  = 3'b010,
		ST_STROBE = 3'b011,
		ST_HOLD   = 3'b100,
		ST_NV     = 3'b101
	} ead_state_type;
endpackage

// [hdl/ead_nv_array.sv]
// Purpose: 2 KB nonvolatile array with one page of column latches
// Assumes: Requests come one at a time from the access sequencer
// Notes:   Commit walks the page one byte per clock while the programming timer runs
`timescale 1ns/10ps
module ead_nv_array #(
	parameter int unsigned PROG_CYCLES = ead_pkg::NV_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// Access from the sequencer
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	input  wire logic [ead_pkg::NV_ADDR_W-1:0] addr,
	input  wire logic [7:0]                    wdata,
	input  wire logic                          launch,
	// Results
	output logic      [7:0]                    rdata,
	output logic                               busy
);
	// Refuse a programming time that the page walk or the 16-bit timer cannot serve
	if (PROG_CYCLES < ead_pkg::NV_PAGE_BYTES || PROG_CYCLES > 65535) begin : g_bad_prog
		$error("PROG_CYCLES must cover one page walk and fit 16 bits");
	end

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0]  mem   [0:(1<<ead_pkg::NV_ADDR_W)-1];
	logic [7:0]  latch [0:ead_pkg::NV_PAGE_BYTES-1];
	logic [ead_pkg::NV_PAGE_BYTES-1:0] flag_q;           // Ninth bit per latch byte
	logic [ead_pkg::NV_ROW_W-1:0]      row_q;
	logic [ead_pkg::NV_COL_W-1:0]      col_q;
	logic [15:0]                       timer_q;
	logic                              walking_q;

	// Address split: upper bits pick the row, lower bits the byte
	wire [ead_pkg::NV_ROW_W-1:0] in_row = addr[ead_pkg::NV_ADDR_W-1:ead_pkg::NV_COL_W];
	wire [ead_pkg::NV_COL_W-1:0] in_col = addr[ead_pkg::NV_COL_W-1:0];
	wire                         load   = wr_en & ~busy;
	wire                         row_change = load & (in_row != row_q);
	wire [ead_pkg::NV_ADDR_W-1:0] commit_addr = {row_q, col_q};
	wire                         col_last = (col_q == ead_pkg::NV_COL_W'(ead_pkg::NV_PAGE_BYTES - 1));

	// Latch data and program data carry no reset; only flags steer behaviour
	always_ff @(posedge sys_clk) begin
		if (load)
			latch[in_col] <= wdata;
		if (walking_q && flag_q[col_q])
			mem[commit_addr] <= latch[col_q];
	end

	// Flag bits: set on load, cleared at end of programming
	// A load to a new row drops the bytes of the old one, so the last row wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag_q <= '0;
			row_q  <= '0;
		end else if (load) begin
			if (row_change)
				flag_q <= '0;
			flag_q[in_col] <= 1'b1;
			row_q <= in_row;
		end else if (busy && timer_q == 16'h0001) begin
			flag_q <= '0;
		end
	end

	// Programming timer and page walk
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy      <= 1'b0;
			walking_q <= 1'b0;
			timer_q   <= '0;
			col_q     <= '0;
		end else if (!busy) begin
			if (launch) begin
				busy      <= 1'b1;
				walking_q <= 1'b1;
				timer_q   <= 16'(PROG_CYCLES);
				col_q     <= '0;
			end
		end else begin
			timer_q <= timer_q - 16'h0001;
			if (walking_q) begin
				col_q <= col_q + ead_pkg::NV_COL_W'(1);
				if (col_last)
					walking_q <= 1'b0;
			end
			if (timer_q == 16'h0001)
				busy <= 1'b0;
		end
	end

	// Read port; blocked while programming
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd_en)
			rdata <= busy ? ead_pkg::NV_BLOCKED_DATA : mem[addr];
	end
endmodule

// [hdl/ead_access.sv]
// Purpose: External data space access unit with on-chip nonvolatile array
// Assumes: Core requests are single-cycle pulses taken only while req_ready is high
// Notes:   Bus phases are counted in core clock periods from an internal tick
//
// Contract
// - Drive low address low port, high address high port
// - Low port carries address first, then data
// - Latch strobe high while low address valid
// - Active-low read strobe on port 3 bit 7
// - Active-low write strobe on port 3 bit 6
// - Plain access lasts six core periods
// - Stretch select widens strobes from 3 to 15
// - Array at 0000h-07FFh when space selected
// - Array reads return stored contents
// - Write loads latches, then programming commits row
// - Accept 1 to 128 latch bytes per page
// - Program only flagged latch bytes
// - Flag set on load, all cleared after programming
// - Latches load one byte per write access
// - Upper 4 bits row, lower 7 bits byte
// - Launch only after 5xh then Axh control writes
// - Busy flag while programming; reads blocked; hardware clears
// - Other instruction between launch writes aborts
// - Last written page wins, others discarded
`timescale 1ns/10ps
module ead_access #(
	parameter int unsigned PROG_CYCLES = ead_pkg::NV_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Mode bits
	input  wire logic        double_speed_mode,
	input  wire logic        bus_stretch_select,
	input  wire logic        nv_space_select,
	// Core data space request
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             req_ready,
	output logic             resp_valid,
	output logic [7:0]       resp_rdata,
	// Control register writes and instruction stream
	input  wire logic        nv_ctrl_wr,
	input  wire logic [7:0]  nv_ctrl_wdata,
	input  wire logic        other_instr,
	output logic             nv_program_in_progress,
	// External bus pins
	output logic [7:0]       low_addr_data_port_out,
	output logic             low_addr_data_port_oe,
	input  wire logic [7:0]  low_addr_data_port_in,
	output logic [7:0]       high_addr_port,
	output logic             ale,
	output logic             p3_7_rd_n,
	output logic             p3_6_wr_n
);
	// Refuse a programming time shorter than one page walk
	if (PROG_CYCLES < ead_pkg::NV_PAGE_BYTES) begin : g_bad_prog
		$error("PROG_CYCLES too small for one page walk");
	end

	// ------------------------------------------------------------------
	// Core clock tick
	// ------------------------------------------------------------------
	// Standard mode halves the oscillator; double speed ticks every cycle
	logic div_q;
	wire  tick = double_speed_mode | div_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			div_q <= 1'b0;
		else
			div_q <= ~div_q & ~double_speed_mode;
	end

	// ------------------------------------------------------------------
	// Request capture and routing
	// ------------------------------------------------------------------
	ead_pkg::ead_state_type state_q, state_d;
	logic [3:0]  cnt_q;
	logic        write_q;
	logic [15:0] addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  ext_rdata_q;
	logic        nv_rd_q;
	logic [7:0]  nv_rdata;
	logic        nv_busy;

	wire take     = req_valid & req_ready;                 // Ignored while not ready, also just after reset
	wire in_range = (req_addr >= ead_pkg::NV_BASE) && (req_addr <= ead_pkg::NV_LAST);
	wire nv_hit   = nv_space_select & in_range;
	wire nv_wr    = take & nv_hit & req_write;
	wire nv_rd    = take & nv_hit & ~req_write;
	wire [3:0] strobe_len = bus_stretch_select ? ead_pkg::STROBE_LONG : ead_pkg::STROBE_TICKS;

	// Phase length for the current state; last tick closes the phase
	wire [3:0] phase_len = (state_q == ead_pkg::ST_ALE)    ? ead_pkg::ALE_TICKS :
	                       (state_q == ead_pkg::ST_SETUP)  ? ead_pkg::SETUP_TICKS :
	                       (state_q == ead_pkg::ST_STROBE) ? strobe_len : ead_pkg::HOLD_TICKS;
	wire       phase_end = tick & (cnt_q == phase_len - 4'h1);

	// ------------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------------
	// Plain cycle is 1 + 1 + 3 + 1 = 6 core periods
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ead_pkg::ST_IDLE:   if (take) state_d = nv_hit ? ead_pkg::ST_NV : ead_pkg::ST_ALE;
			ead_pkg::ST_ALE:    if (phase_end) state_d = ead_pkg::ST_SETUP;
			ead_pkg::ST_SETUP:  if (phase_end) state_d = ead_pkg::ST_STROBE;
			ead_pkg::ST_STROBE: if (phase_end) state_d = ead_pkg::ST_HOLD;
			ead_pkg::ST_HOLD:   if (phase_end) state_d = ead_pkg::ST_IDLE;
			ead_pkg::ST_NV:     state_d = ead_pkg::ST_IDLE;
			default:            state_d = ead_pkg::ST_IDLE;
		endcase
	end

	// State, phase counter and captured request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ead_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			write_q <= 1'b0;
			addr_q  <= 16'h0000;
			wdata_q <= 8'h00;
			nv_rd_q <= 1'b0;
		end else begin
			state_q <= state_d;
			nv_rd_q <= nv_rd;
			if (state_d != state_q)
				cnt_q <= 4'h0;
			else if (tick)
				cnt_q <= cnt_q + 4'h1;
			if (take) begin
				write_q <= req_write;
				addr_q  <= req_addr;
				wdata_q <= req_wdata;
			end
		end
	end

	// Pin values decoded from the next state so the pins are flop outputs
	wire ext_d     = (state_d != ead_pkg::ST_IDLE) && (state_d != ead_pkg::ST_NV);
	wire addr_ph_d = (state_d == ead_pkg::ST_ALE) || (state_d == ead_pkg::ST_SETUP);
	wire data_ph_d = (state_d == ead_pkg::ST_STROBE) || (state_d == ead_pkg::ST_HOLD);
	wire [15:0] a_d = take ? req_addr : addr_q;
	wire        w_d = take ? req_write : write_q;
	wire [7:0]  d_d = take ? req_wdata : wdata_q;
	wire        sample = (state_q == ead_pkg::ST_STROBE) & phase_end & ~write_q;

	// ------------------------------------------------------------------
	// External pins
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			low_addr_data_port_out <= 8'h00;
			low_addr_data_port_oe  <= 1'b0;
			high_addr_port         <= 8'h00;
			ale                    <= 1'b0;
			p3_7_rd_n              <= 1'b1;
			p3_6_wr_n              <= 1'b1;
		end else begin
			if (ext_d)
				high_addr_port <= a_d[15:8];
			low_addr_data_port_out <= addr_ph_d ? a_d[7:0] : d_d;
			low_addr_data_port_oe  <= addr_ph_d | (data_ph_d & w_d);
			ale       <= (state_d == ead_pkg::ST_ALE);
			p3_7_rd_n <= ~((state_d == ead_pkg::ST_STROBE) & ~w_d);
			p3_6_wr_n <= ~((state_d == ead_pkg::ST_STROBE) & w_d);
		end
	end

	// Read data is caught on the last tick of the strobe, before it rises
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ext_rdata_q <= 8'h00;
		else if (sample)
			ext_rdata_q <= low_addr_data_port_in;
	end

	// ------------------------------------------------------------------
	// Core answer
	// ------------------------------------------------------------------
	wire ext_done = (state_q == ead_pkg::ST_HOLD) & phase_end;
	wire nv_done  = (state_q == ead_pkg::ST_NV);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_ready  <= 1'b0;
			resp_valid <= 1'b0;
			resp_rdata <= 8'h00;
		end else begin
			req_ready  <= (state_d == ead_pkg::ST_IDLE) & ~take;
			resp_valid <= ext_done | nv_done;
			if (ext_done & ~write_q)
				resp_rdata <= ext_rdata_q;
			else if (nv_done & nv_rd_q)
				resp_rdata <= nv_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Programming launch sequence
	// ------------------------------------------------------------------
	// Only a 5xh write arms; any other instruction or control value disarms
	logic armed_q;
	wire  first_w  = nv_ctrl_wr & (nv_ctrl_wdata[7:4] == ead_pkg::LAUNCH_FIRST_HI);
	wire  second_w = nv_ctrl_wr & (nv_ctrl_wdata[7:4] == ead_pkg::LAUNCH_SECOND_HI);
	wire  launch   = armed_q & second_w & ~other_instr;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			armed_q <= 1'b0;
		else if (nv_ctrl_wr)
			armed_q <= first_w;
		else if (other_instr)
			armed_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Nonvolatile array
	// ------------------------------------------------------------------
	ead_nv_array #(
		.PROG_CYCLES (PROG_CYCLES)
	) u_nv (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wr_en   (nv_wr),
		.rd_en   (nv_rd),
		.addr    (req_addr[ead_pkg::NV_ADDR_W-1:0]),
		.wdata   (req_wdata),
		.launch  (launch),
		.rdata   (nv_rdata),
		.busy    (nv_busy)
	);

	// Busy flag as seen by software, straight from the programming flop so that
	// it shows exactly the cycles in which array reads are blocked
	assign nv_program_in_progress = nv_busy;
endmodule

// [verification/ead_ext_mem.sv]
// Purpose: External byte memory on the multiplexed bus, seen from the far side
// Assumes: Address is latched as the latch strobe falls
// Notes:   Read answer appears RD_DELAY_NS after the read strobe falls
`timescale 1ns/10ps
module ead_ext_mem #(
	parameter int unsigned RD_DELAY_NS = 5
) (
	// Bus from the unit
	input  wire logic [7:0] low_addr_data_port_out,
	input  wire logic [7:0] high_addr_port,
	input  wire logic       ale,
	input  wire logic       p3_7_rd_n,
	input  wire logic       p3_6_wr_n,
	// Data back to the unit
	output logic      [7:0] mem_data
);
	logic [7:0]  mem [0:65535];
	logic [15:0] lat_addr;
	logic [7:0]  last;

	initial mem_data = 8'h00;
	// Capture low address on the latch strobe
	always @(negedge ale) lat_addr = {high_addr_port, low_addr_data_port_out};
	// Data is still held as the write strobe rises
	always @(posedge p3_6_wr_n) mem[lat_addr] = low_addr_data_port_out;
	// Released lines show the inverse so a stale value never passes
	always @(p3_7_rd_n) begin
		if (p3_7_rd_n === 1'b0) begin
			last = mem[lat_addr];
			mem_data <= #(RD_DELAY_NS) last;
		end else begin
			mem_data <= ~last;
		end
	end
endmodule

// [verification/ead_access_properties.sv]
// Purpose: Port checks for the data space access unit
// Assumes: Mode inputs change only while the unit is idle
// Notes:   Strobe and busy lengths are counted by helper registers
`timescale 1ns/10ps
module ead_access_properties #(
	parameter int unsigned PROG_CYCLES = 4096
) (
	// Clock, reset and modes
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        double_speed_mode,
	input wire logic        bus_stretch_select,
	input wire logic        nv_space_select,
	// Core side
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [15:0] req_addr,
	input wire logic [7:0]  req_wdata,
	input wire logic        req_ready,
	input wire logic        resp_valid,
	input wire logic [7:0]  resp_rdata,
	input wire logic        nv_ctrl_wr,
	input wire logic [7:0]  nv_ctrl_wdata,
	input wire logic        nv_program_in_progress,
	// Bus pins
	input wire logic [7:0]  low_addr_data_port_out,
	input wire logic        low_addr_data_port_oe,
	input wire logic [7:0]  high_addr_port,
	input wire logic        ale,
	input wire logic        p3_7_rd_n,
	input wire logic        p3_6_wr_n
);
	// ------------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------------
	logic [7:0]  low_q;
	logic [15:0] busy_q;
	logic [15:0] addr_q;
	logic [7:0]  wd_q;
	wire take   = req_valid && req_ready;
	wire nv_hit = nv_space_select && (req_addr <= ead_pkg::NV_LAST);
	wire strb_n = p3_7_rd_n && p3_6_wr_n;
	wire ctrl_a = nv_ctrl_wr && (nv_ctrl_wdata[7:4] == ead_pkg::LAUNCH_SECOND_HI);

	// Lengths count up while active so the closing edge sees the full width
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			low_q  <= 8'h00;
			busy_q <= 16'h0000;
			addr_q <= 16'h0000;
			wd_q   <= 8'h00;
		end else begin
			low_q  <= strb_n ? 8'h00 : low_q + 8'h01;
			busy_q <= nv_program_in_progress ? busy_q + 16'h0001 : 16'h0000;
			addr_q <= take ? req_addr : addr_q;
			wd_q   <= take ? req_wdata : wd_q;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_idle_strobes; req_ready |-> p3_7_rd_n && p3_6_wr_n; endproperty
	a_idle_strobes: assert property (p_idle_strobes) else $error("strobe low while idle");
	property p_addr_out;
		$rose(ale) |-> low_addr_data_port_oe && high_addr_port == addr_q[15:8] && low_addr_data_port_out == addr_q[7:0];
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("address wrong at latch strobe");
	property p_ale_hold; $fell(ale) |-> $stable(low_addr_data_port_out) && $stable(high_addr_port); endproperty
	a_ale_hold: assert property (p_ale_hold) else $error("address moved as latch strobe fell");
	property p_rd_release; !p3_7_rd_n |-> !low_addr_data_port_oe; endproperty
	a_rd_release: assert property (p_rd_release) else $error("low port driven during read");
	property p_wr_data; !p3_6_wr_n |-> low_addr_data_port_oe && low_addr_data_port_out == wd_q; endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data not on low port");
	property p_plain_fast;
		double_speed_mode && !bus_stretch_select && $fell(p3_7_rd_n) |-> ##1 !p3_7_rd_n [*2] ##1 p3_7_rd_n;
	endproperty
	a_plain_fast: assert property (p_plain_fast) else $error("plain read strobe not three periods");
	property p_width;
		$rose(strb_n) |-> low_q == (bus_stretch_select ? 15 : 3) * (double_speed_mode ? 1 : 2);
	endproperty
	a_width: assert property (p_width) else $error("strobe width wrong");
	property p_nv_route; take && nv_hit |=> !ale ##1 !ale && resp_valid; endproperty
	a_nv_route: assert property (p_nv_route) else $error("array access reached the bus");
	property p_blocked;
		nv_program_in_progress && take && nv_hit && !req_write |-> ##2 resp_valid && resp_rdata == ead_pkg::NV_BLOCKED_DATA;
	endproperty
	a_blocked: assert property (p_blocked) else $error("array read not blocked while busy");
	property p_launch; $rose(nv_program_in_progress) |-> $past(ctrl_a) || $past(ctrl_a, 2); endproperty
	a_launch: assert property (p_launch) else $error("busy without launch write");
	property p_busy_len;
		$fell(nv_program_in_progress) |-> busy_q >= PROG_CYCLES && busy_q <= PROG_CYCLES + 300;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming time wrong");

	c_stretch: cover property ($rose(strb_n) && bus_stretch_select);
	c_launch:  cover property ($rose(nv_program_in_progress));
	c_blocked: cover property (nv_program_in_progress && take && nv_hit);
endmodule

bind ead_access ead_access_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
	.sys_clk(sys_clk), .rst(rst), .double_speed_mode(double_speed_mode),
	.bus_stretch_select(bus_stretch_select), .nv_space_select(nv_space_select),
	.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
	.req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .nv_ctrl_wr(nv_ctrl_wr),
	.nv_ctrl_wdata(nv_ctrl_wdata), .nv_program_in_progress(nv_program_in_progress),
	.low_addr_data_port_out(low_addr_data_port_out), .low_addr_data_port_oe(low_addr_data_port_oe),
	.high_addr_port(high_addr_port), .ale(ale), .p3_7_rd_n(p3_7_rd_n), .p3_6_wr_n(p3_6_wr_n)
);

// [verification/ead_access_tb.sv]
// Purpose: Self-checking bench for the data space access unit
// Assumes: Inputs change at the falling edge; short programming time
// Notes:   Table rows cover bus modes, hand tests cover the array
`timescale 1ns/10ps
module ead_access_tb;
	typedef struct {logic fast; logic slow; logic sel; logic [15:0] addr; logic [7:0] data; int cyc;} ead_row_type;
	logic sys_clk, rst, double_speed_mode, bus_stretch_select, nv_space_select, req_valid, req_write;
	logic [15:0] req_addr;
	logic [7:0]  req_wdata, resp_rdata, nv_ctrl_wdata, low_addr_data_port_out, high_addr_port, mem_data;
	logic        req_ready, resp_valid, nv_ctrl_wr, other_instr, nv_program_in_progress;
	logic        low_addr_data_port_oe, ale, p3_7_rd_n, p3_6_wr_n;
	wire  [7:0]  low_addr_data_port_in = low_addr_data_port_oe ? low_addr_data_port_out : mem_data;
	int          num_errors, total_checks, cycles, n;
	// Expected edges from take to answer: 6 or 18 core periods; standard mode may lose one to the tick phase
	ead_row_type rows [6] = '{'{1, 0, 0, 16'h1234, 8'ha5, 6}, '{0, 0, 0, 16'hff00, 8'h5a, 12},
		'{1, 1, 0, 16'h00ff, 8'h3c, 18}, '{0, 1, 0, 16'h8001, 8'hc3, 36},
		'{1, 0, 1, 16'h0800, 8'h96, 6}, '{0, 0, 0, 16'h0000, 8'h0f, 12}};
	logic [15:0] nv_a [4] = '{16'h0180, 16'h01ff, 16'h0181, 16'h0105};
	logic [7:0]  nv_d [4] = '{8'h22, 8'h33, 8'hxx, 8'hxx};

	ead_access #(.PROG_CYCLES(200)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .double_speed_mode(double_speed_mode),
		.bus_stretch_select(bus_stretch_select), .nv_space_select(nv_space_select),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .nv_ctrl_wr(nv_ctrl_wr),
		.nv_ctrl_wdata(nv_ctrl_wdata), .other_instr(other_instr), .nv_program_in_progress(nv_program_in_progress),
		.low_addr_data_port_out(low_addr_data_port_out), .low_addr_data_port_oe(low_addr_data_port_oe),
		.low_addr_data_port_in(low_addr_data_port_in), .high_addr_port(high_addr_port), .ale(ale),
		.p3_7_rd_n(p3_7_rd_n), .p3_6_wr_n(p3_6_wr_n));
	ead_ext_mem u_mem (.low_addr_data_port_out(low_addr_data_port_out), .high_addr_port(high_addr_port),
		.ale(ale), .p3_7_rd_n(p3_7_rd_n), .p3_6_wr_n(p3_6_wr_n), .mem_data(mem_data));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk_v(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_n(input string name, input int exp, input int got, input int tol);
		total_checks++;
		if (got < exp - tol || got > exp + tol) begin
			num_errors++;
			$display("MISMATCH %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	// Bounded waits, so a stuck handshake ends in a failed count
	task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d, output int k);
		k = 0;
		while (req_ready !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge sys_clk);
		req_valid = 1'b0;
		k = 0;
		while (resp_valid !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
	endtask
	// Launch pair; brk puts another instruction between the two writes
	task automatic launch(input logic brk, input logic [3:0] lo);
		nv_ctrl_wr = 1'b1;
		nv_ctrl_wdata = {4'h5, lo};
		@(negedge sys_clk);
		if (brk) begin
			nv_ctrl_wr = 1'b0;
			other_instr = 1'b1;
			@(negedge sys_clk);
			other_instr = 1'b0;
			nv_ctrl_wr = 1'b1;
		end
		nv_ctrl_wdata = {4'ha, lo};
		@(negedge sys_clk);
		nv_ctrl_wr = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic results();
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Cut a hang short well past the expected run
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{rst, double_speed_mode, bus_stretch_select, nv_space_select, req_valid, req_write} = 6'h20;
		{req_addr, req_wdata, nv_ctrl_wdata, nv_ctrl_wr, other_instr} = 34'h0;
		repeat (20) @(negedge sys_clk);
		chk_v("pins in reset", 8'h06, {3'h0, ale, low_addr_data_port_oe, p3_7_rd_n, p3_6_wr_n, req_ready});
		rst = 1'b0;
		@(negedge sys_clk);
		foreach (rows[i]) begin
			double_speed_mode = rows[i].fast;
			bus_stretch_select = rows[i].slow;
			nv_space_select = rows[i].sel;
			access(1'b1, rows[i].addr, rows[i].data, n);
			chk_n("write cycles", rows[i].cyc, n, rows[i].fast ? 0 : 1);
			access(1'b0, rows[i].addr, 8'h00, n);
			chk_n("read cycles", rows[i].cyc, n, rows[i].fast ? 0 : 1);
			chk_v("read data", rows[i].data, resp_rdata);
		end
		{double_speed_mode, bus_stretch_select, nv_space_select} = 3'h5;
		access(1'b1, 16'h0105, 8'h11, n);
		access(1'b1, 16'h0180, 8'h22, n);
		access(1'b1, 16'h01ff, 8'h33, n);
		chk_n("latch write cycles", 1, n, 0);
		launch(1'b0, 4'h0);
		chk_v("busy after launch", 8'h01, {7'h0, nv_program_in_progress});
		access(1'b0, 16'h0180, 8'h00, n);
		chk_v("read while busy", ead_pkg::NV_BLOCKED_DATA, resp_rdata);
		n = 0;
		while (nv_program_in_progress !== 1'b0 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk_v("busy cleared", 8'h00, {7'h0, nv_program_in_progress});
		foreach (nv_a[i]) begin
			access(1'b0, nv_a[i], 8'h00, n);
			chk_v("array data", nv_d[i], resp_rdata);
		end
		access(1'b1, 16'h0181, 8'h44, n);
		launch(1'b1, 4'h0);
		chk_v("busy after broken launch", 8'h00, {7'h0, nv_program_in_progress});
		launch(1'b0, 4'h9);
		n = 0;
		while (nv_program_in_progress !== 1'b0 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		access(1'b0, 16'h0181, 8'h00, n);
		chk_v("second program", 8'h44, resp_rdata);
		access(1'b0, 16'h0180, 8'h00, n);
		chk_v("earlier byte kept", 8'h22, resp_rdata);
		// Reset in the middle of programming
		access(1'b1, 16'h0182, 8'h55, n);
		launch(1'b0, 4'h0);
		rst = 1'b1;
		@(negedge sys_clk);
		chk_v("pins in mid reset", 8'h06, {3'h0, ale, low_addr_data_port_oe, p3_7_rd_n, p3_6_wr_n, req_ready});
		chk_v("busy in mid reset", 8'h00, {7'h0, nv_program_in_progress});
		rst = 1'b0;
		access(1'b0, 16'h0180, 8'h00, n);
		chk_v("array kept over reset", 8'h22, resp_rdata);
		results();
	end
endmodule
